/* core/mafpp_core.sv */
// Purpose: Muxed-address programming port of a parallel flash, array included
// Assumes: Strobes come from pins and are synchronised to CLK_SYS
// Notes: IS_4M selects the 4 Mbit map; array writes only clear bits
// Notes on behaviour
// - Row address bits 10..0 captured on falling edge of row/column strobe.
// - Column address bits 21..11 captured on rising edge of row/column strobe.
// - 2 Mbit decodes address bits 17..0; 4 Mbit decodes bits 18..0.
// - Output strobe low, write strobe high, reset high: device drives read byte.
// - Write strobe low, output strobe high: device captures data byte.
// - No chip select; data lines float unless reading and out of reset.
// - ID mode: A1=A0 gives maker code, A1=0 A0=1 gives part code.
// - Commands: AA to 5555, 55 to 2AAA, then command byte to 5555.
// - Chip erase is six writes ending with 10 to 5555.
// - Sector erase sixth write is 30 at any address in the 4 KB sector.
// - Block erase sixth write is 50 at any address in the block.
// - Command match uses address bits 15..0 only, bit 15 must be zero.
// - ID mode left on three-write F0 sequence or single F0 write anywhere.
// - 2 Mbit: sixteen 16 KB blocks, block 15 boot, block 0 four sectors.
// - 4 Mbit: eight 64 KB blocks, block 7 boot, block 0 sixteen sectors.
// - Sector and block erase clear one sector or one block; chip erase clears every unlocked block.
// - Boot lock pin low refuses boot block erase.
// - After ID exit the device returns to normal array reads.
`include "mafpp_defs.svh"
`default_nettype none
module mafpp_core #(
	parameter bit IS_4M = 1'b0
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic RST_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic ROW_COL,
	input wire logic BOOT_LOCK_PIN_N,
	input wire logic WP_N,
	input wire logic [`MAFPP_ROW_W-1:0] ADDR,
	input wire logic [7:0] DATA_I,
	output logic [7:0] DATA_O,
	output logic DATA_OE,
	output logic BUSY
);

	localparam int TOP = IS_4M ? `MAFPP_TOP_4M : `MAFPP_TOP_2M;
	localparam int DEPTH = 1 << (TOP + 1);
	localparam int BLK_LSB = IS_4M ? `MAFPP_BLK_LSB_4M : `MAFPP_BLK_LSB_2M;
	localparam logic [7:0] PART_CODE = IS_4M ? `MAFPP_PART_CODE_4M : `MAFPP_PART_CODE_2M;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	mafpp_pkg::mafpp_pins_t pins_a_r, pins_s_r, pins_d_r;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			pins_a_r <= '{rst_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, row_col: 1'b1,
				boot_lock_pin_n: 1'b0, wp_n: 1'b0, addr: '0, data: '0};
			pins_s_r <= '{rst_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, row_col: 1'b1,
				boot_lock_pin_n: 1'b0, wp_n: 1'b0, addr: '0, data: '0};
			pins_d_r <= '{rst_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, row_col: 1'b1,
				boot_lock_pin_n: 1'b0, wp_n: 1'b0, addr: '0, data: '0};
		end else begin
			pins_a_r <= '{rst_n: RST_N, oe_n: OE_N, we_n: WE_N, row_col: ROW_COL,
				boot_lock_pin_n: BOOT_LOCK_PIN_N, wp_n: WP_N, addr: ADDR, data: DATA_I};
			pins_s_r <= pins_a_r;
			pins_d_r <= pins_s_r;
		end
	end

	// ----------------------------------------
	// Strobe edges
	// ----------------------------------------
	logic rc_fall, rc_rise, we_rise, active;
	assign rc_fall = pins_d_r.row_col & ~pins_s_r.row_col;
	assign rc_rise = ~pins_d_r.row_col & pins_s_r.row_col;
	assign we_rise = ~pins_d_r.we_n & pins_s_r.we_n & pins_s_r.oe_n;
	assign active = pins_s_r.rst_n;

	// ----------------------------------------
	// Address capture
	// ----------------------------------------
	logic [`MAFPP_ADDR_W-1:0] addr_r;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			addr_r <= '0;
		end else if (rc_fall) begin
			addr_r[`MAFPP_ROW_W-1:0] <= pins_s_r.addr;
		end else if (rc_rise) begin
			addr_r[`MAFPP_ADDR_W-1:`MAFPP_ROW_W] <= pins_s_r.addr;
		end
	end

	logic [TOP:0] arr_addr;
	assign arr_addr = addr_r[TOP:0];

	// ----------------------------------------
	// Write data capture
	// ----------------------------------------
	logic [7:0] wdata_r;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			wdata_r <= '0;
		end else if (~pins_s_r.we_n & pins_s_r.oe_n) begin
			wdata_r <= pins_s_r.data;
		end
	end

	// ----------------------------------------
	// Command decoder
	// ----------------------------------------
	logic is_a1, is_a2, boot_hit, guard_ok;
	assign is_a1 = addr_r[`MAFPP_CMD_HI:0] == `MAFPP_CMD_ADDR_1;
	assign is_a2 = addr_r[`MAFPP_CMD_HI:0] == `MAFPP_CMD_ADDR_2;
	assign boot_hit = &arr_addr[TOP:BLK_LSB];
	assign guard_ok = boot_hit ? pins_d_r.boot_lock_pin_n : pins_d_r.wp_n;

	mafpp_pkg::mafpp_state_t state_r, state_nxt;
	logic id_mode_r, id_mode_nxt;
	logic [TOP:0] lo_nxt, hi_nxt, lo_r, hi_r, wptr_r;

	always_comb begin
		state_nxt = state_r;
		id_mode_nxt = id_mode_r;
		lo_nxt = arr_addr;
		hi_nxt = arr_addr;
		if (we_rise) begin
			state_nxt = mafpp_pkg::MAFPP_IDLE;
			if (wdata_r == `MAFPP_DAT_ID_EXIT && state_r != mafpp_pkg::MAFPP_PROG) begin
				id_mode_nxt = 1'b0;
			end
			case (state_r)
				mafpp_pkg::MAFPP_IDLE: begin
					if (is_a1 && wdata_r == `MAFPP_DAT_UNLOCK_1) begin
						state_nxt = mafpp_pkg::MAFPP_U1;
					end
				end
				mafpp_pkg::MAFPP_U1: begin
					if (is_a2 && wdata_r == `MAFPP_DAT_UNLOCK_2) begin
						state_nxt = mafpp_pkg::MAFPP_U2;
					end
				end
				mafpp_pkg::MAFPP_U2: begin
					if (is_a1) begin
						case (wdata_r)
							`MAFPP_DAT_ERASE_SETUP: state_nxt = mafpp_pkg::MAFPP_E1;
							`MAFPP_DAT_PROGRAM: state_nxt = mafpp_pkg::MAFPP_PROG;
							`MAFPP_DAT_ID_ENTRY: id_mode_nxt = 1'b1;
							default: state_nxt = mafpp_pkg::MAFPP_IDLE;
						endcase
					end
				end
				mafpp_pkg::MAFPP_PROG: begin
					if (guard_ok) begin
						state_nxt = mafpp_pkg::MAFPP_BUSY_PROG;
					end
				end
				mafpp_pkg::MAFPP_E1: begin
					if (is_a1 && wdata_r == `MAFPP_DAT_UNLOCK_1) begin
						state_nxt = mafpp_pkg::MAFPP_E2;
					end
				end
				mafpp_pkg::MAFPP_E2: begin
					if (is_a2 && wdata_r == `MAFPP_DAT_UNLOCK_2) begin
						state_nxt = mafpp_pkg::MAFPP_E3;
					end
				end
				mafpp_pkg::MAFPP_E3: begin
					if (is_a1 && wdata_r == `MAFPP_DAT_CHIP_ERASE) begin
						lo_nxt = '0;
						hi_nxt = '1;
						state_nxt = mafpp_pkg::MAFPP_BUSY_CHIP;
					end else if (wdata_r == `MAFPP_DAT_SECTOR_ERASE && guard_ok) begin
						lo_nxt = {arr_addr[TOP:`MAFPP_SECT_LSB], {`MAFPP_SECT_LSB{1'b0}}};
						hi_nxt = {arr_addr[TOP:`MAFPP_SECT_LSB], {`MAFPP_SECT_LSB{1'b1}}};
						state_nxt = mafpp_pkg::MAFPP_BUSY_ERASE;
					end else if (wdata_r == `MAFPP_DAT_BLOCK_ERASE && guard_ok) begin
						lo_nxt = {arr_addr[TOP:BLK_LSB], {BLK_LSB{1'b0}}};
						hi_nxt = {arr_addr[TOP:BLK_LSB], {BLK_LSB{1'b1}}};
						state_nxt = mafpp_pkg::MAFPP_BUSY_ERASE;
					end
				end
				default: state_nxt = state_r;
			endcase
		end
	end

	// ----------------------------------------
	// Array and embedded operations
	// ----------------------------------------
	logic [7:0] mem [DEPTH];
	logic erasing, chip_skip;
	assign erasing = state_r == mafpp_pkg::MAFPP_BUSY_ERASE
		|| state_r == mafpp_pkg::MAFPP_BUSY_CHIP;
	// Chip erase spares locked regions
	assign chip_skip = state_r == mafpp_pkg::MAFPP_BUSY_CHIP
		&& ((&wptr_r[TOP:BLK_LSB]) ? ~pins_d_r.boot_lock_pin_n : ~pins_d_r.wp_n);
	logic seq_step;
	assign seq_step = active && !erasing && state_r != mafpp_pkg::MAFPP_BUSY_PROG;

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_r <= mafpp_pkg::MAFPP_IDLE;
		end else if (!active) begin
			state_r <= mafpp_pkg::MAFPP_IDLE;
		end else if (erasing) begin
			if (wptr_r == hi_r) begin
				state_r <= mafpp_pkg::MAFPP_IDLE;
			end
		end else if (state_r == mafpp_pkg::MAFPP_BUSY_PROG) begin
			state_r <= mafpp_pkg::MAFPP_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			id_mode_r <= 1'b0;
		end else if (!active) begin
			id_mode_r <= 1'b0;
		end else if (seq_step) begin
			id_mode_r <= id_mode_nxt;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			lo_r <= '0;
			hi_r <= '0;
		end else if (seq_step) begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end

	// ----------------------------------------
	// Erase pointer
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			wptr_r <= '0;
		end else if (active && erasing) begin
			wptr_r <= wptr_r + 1'b1;
		end else if (seq_step) begin
			wptr_r <= lo_nxt;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (active && erasing && !chip_skip) begin
			mem[wptr_r] <= `MAFPP_ERASE_FILL;
		end else if (active && state_r == mafpp_pkg::MAFPP_BUSY_PROG) begin
			mem[lo_r] <= mem[lo_r] & wdata_r;
		end
	end

	assign BUSY = state_r == mafpp_pkg::MAFPP_BUSY_PROG || erasing;

	// ----------------------------------------
	// Identification codes
	// ----------------------------------------
	logic [7:0] id_code;

	always_comb begin
		case (addr_r[`MAFPP_ID_SEL_HI:`MAFPP_ID_SEL_LO])
			`MAFPP_ID_PART_SEL: id_code = PART_CODE;
			`MAFPP_ID_NONE_SEL: id_code = '0;
			default: id_code = `MAFPP_MAKER_CODE;
		endcase
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic reading;
	assign reading = active & ~pins_s_r.oe_n & pins_s_r.we_n;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			DATA_OE <= 1'b0;
		end else begin
			DATA_OE <= reading;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			DATA_O <= '0;
		end else if (id_mode_r) begin
			DATA_O <= id_code;
		end else begin
			DATA_O <= mem[arr_addr];
		end
	end

endmodule
`default_nettype wire

/* core/mafpp_defs.svh */
// Purpose: Constants for the muxed-address flash programming port
// Assumes: One system clock at 100 MHz
// Notes: Included by the package and the core
`ifndef MAFPP_DEFS_SVH
`define MAFPP_DEFS_SVH

`define MAFPP_ROW_W 11
`define MAFPP_ADDR_W 22
`define MAFPP_CMD_ADDR_1 16'h5555
`define MAFPP_CMD_ADDR_2 16'h2aaa
`define MAFPP_DAT_UNLOCK_1 8'haa
`define MAFPP_DAT_UNLOCK_2 8'h55
`define MAFPP_DAT_ERASE_SETUP 8'h80
`define MAFPP_DAT_PROGRAM 8'ha0
`define MAFPP_DAT_ID_ENTRY 8'h90
`define MAFPP_DAT_ID_EXIT 8'hf0
`define MAFPP_DAT_CHIP_ERASE 8'h10
`define MAFPP_DAT_SECTOR_ERASE 8'h30
`define MAFPP_DAT_BLOCK_ERASE 8'h50
`define MAFPP_ERASE_FILL 8'hff
`define MAFPP_MAKER_CODE 8'h5a
`define MAFPP_PART_CODE_2M 8'h21
`define MAFPP_PART_CODE_4M 8'h41
`define MAFPP_SECT_LSB 12
`define MAFPP_BLK_LSB_2M 14
`define MAFPP_BLK_LSB_4M 16
`define MAFPP_TOP_2M 17
`define MAFPP_TOP_4M 18
`define MAFPP_CMD_HI 15
`define MAFPP_ID_SEL_HI 1
`define MAFPP_ID_SEL_LO 0
`define MAFPP_ID_PART_SEL 2'h1
`define MAFPP_ID_NONE_SEL 2'h2

`endif

/* core/mafpp_pkg.sv */
// Purpose: Types for the muxed-address flash programming port
// Assumes: mafpp_defs.svh on the include path
// Notes: Carries pin groups and sequencer states
`include "mafpp_defs.svh"
`default_nettype none
package mafpp_pkg;

	typedef struct packed {
		logic rst_n;
		logic oe_n;
		logic we_n;
		logic row_col;
		logic boot_lock_pin_n;
		logic wp_n;
		logic [`MAFPP_ROW_W-1:0] addr;
		logic [7:0] data;
	} mafpp_pins_t;

	typedef enum logic [3:0] {
		MAFPP_IDLE, MAFPP_U1, MAFPP_U2, MAFPP_PROG, MAFPP_E1, MAFPP_E2,
		MAFPP_E3, MAFPP_BUSY_PROG, MAFPP_BUSY_ERASE, MAFPP_BUSY_CHIP
	} mafpp_state_t;

endpackage
`default_nettype wire

/* bench/mafpp_chk.sv */
// Purpose: Pin-level checks of the programming port
// Assumes: Strobe levels held at least 5 cycles
// Notes: Bound to mafpp_core
`default_nettype none
module mafpp_chk (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic RST_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic ROW_COL,
	input wire logic [10:0] ADDR,
	input wire logic [7:0] DATA_O,
	input wire logic DATA_OE,
	input wire logic BUSY
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	chk_float_idle: assert property (OE_N [*5] |-> !DATA_OE)
		else $error("data driven with output strobe high");
	chk_float_reset: assert property (!RST_N [*5] |-> !DATA_OE)
		else $error("data driven in device reset");
	chk_float_write: assert property (!WE_N [*5] |-> !DATA_OE)
		else $error("data driven during write");
	chk_read_drive: assert property ((!OE_N && WE_N && RST_N) [*6] |-> DATA_OE)
		else $error("read not driven in time");
	chk_no_early: assert property ($fell(OE_N) |-> !DATA_OE ##1 !DATA_OE)
		else $error("data driven too early");
	chk_drop_time: assert property ($rose(OE_N) |-> ##[3:5] !DATA_OE)
		else $error("data not released in time");
	chk_data_steady: assert property (DATA_OE && $past(DATA_OE) && $stable(ADDR)
		&& $stable(ROW_COL) && !BUSY |-> $stable(DATA_O))
		else $error("read data moved");
	chk_busy_quiet: assert property ((!OE_N && WE_N) [*8] |-> !$rose(BUSY))
		else $error("busy without write");
	cover property ($rose(DATA_OE));
	cover property ($fell(BUSY));
	cover property (DATA_OE && DATA_O == 8'h5a);
endmodule
bind mafpp_core mafpp_chk chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .RST_N(RST_N),
	.OE_N(OE_N), .WE_N(WE_N), .ROW_COL(ROW_COL), .ADDR(ADDR), .DATA_O(DATA_O),
	.DATA_OE(DATA_OE), .BUSY(BUSY));
`default_nettype wire

/* bench/mafpp_prog.sv */
// Purpose: Device programmer driving the strobes
// Assumes: Pins change at falling clock edge
// Notes: Every level held 6 cycles
`default_nettype none
module mafpp_prog (
	input wire logic CLK_SYS,
	input wire logic [7:0] DQ,
	input wire logic BUSY,
	output var mafpp_pkg::mafpp_pins_t P
);
	timeunit 1ns;
	timeprecision 1ns;
	int stall_count = 0;
	initial P = '1;
	task automatic hold();
		repeat (6) @(negedge CLK_SYS);
	endtask
	task automatic sel(input logic [21:0] a);
		P.addr = a[10:0];
		P.row_col = 1'b0;
		hold();
		P.addr = a[21:11];
		P.row_col = 1'b1;
		hold();
	endtask
	task automatic strobe(input logic [21:0] a, input logic [7:0] d);
		sel(a);
		P.data = d;
		P.we_n = 1'b0;
		hold();
		P.we_n = 1'b1;
		hold();
		P.data = ~d;
	endtask
	task automatic wr(input logic [21:0] a, input logic [7:0] d);
		strobe(a, d);
		for (int i = 0; i < 20000 && BUSY !== 1'b0; i++) @(negedge CLK_SYS);
		if (BUSY !== 1'b0) stall_count++;
	endtask
	task automatic rd(input logic [21:0] a, output logic [7:0] d);
		sel(a);
		P.oe_n = 1'b0;
		hold();
		d = DQ;
		P.oe_n = 1'b1;
		hold();
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(22'h005555, 8'haa);
		wr(22'h002aaa, 8'h55);
		wr(22'h005555, c);
	endtask
endmodule
`default_nettype wire

/* bench/mafpp_core_tb.sv */
// Purpose: Self-checking bench of mafpp_core
// Assumes: 2 Mbit map, array erased before use
// Notes: Stimulus through mafpp_prog
`default_nettype none
module mafpp_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic oe;
	logic busy;
	logic [7:0] dout;
	mafpp_pkg::mafpp_pins_t p;
	wire [7:0] dq = oe ? dout : p.data;
	int err_count = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	mafpp_prog prog_u (.CLK_SYS(clk), .DQ(dq), .BUSY(busy), .P(p));
	mafpp_core #(.IS_4M(1'b0)) dut_u (.CLK_SYS(clk), .RESET(rst), .RST_N(p.rst_n),
		.OE_N(p.oe_n), .WE_N(p.we_n), .ROW_COL(p.row_col), .BOOT_LOCK_PIN_N(p.boot_lock_pin_n),
		.WP_N(p.wp_n), .ADDR(p.addr), .DATA_I(dq), .DATA_O(dout), .DATA_OE(oe), .BUSY(busy));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [21:0] a, input logic [7:0] e);
		logic [7:0] v;
		prog_u.rd(a, v);
		chk(v, e);
	endtask
	task automatic er(input logic [21:0] a, input logic [7:0] c);
		prog_u.cmd(8'h80);
		prog_u.wr(22'h005555, 8'haa);
		prog_u.wr(22'h002aaa, 8'h55);
		prog_u.wr(a, c);
	endtask
	task automatic pg(input logic [21:0] a, input logic [7:0] d);
		prog_u.cmd(8'ha0);
		prog_u.wr(a, d);
	endtask
	task automatic t_float();
		prog_u.P.rst_n = 1'b0;
		prog_u.P.oe_n = 1'b0;
		repeat (8) @(negedge clk);
		chk({7'h00, oe}, 8'h00);
		prog_u.P.oe_n = 1'b1;
		prog_u.P.rst_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask
	task automatic t_sector();
		er(22'h001000, 8'h30);
		rc(22'h001010, 8'hff);
		pg(22'h001010, 8'h00);
		rc(22'h001010, 8'h00);
		er(22'h002000, 8'h30);
		rc(22'h001010, 8'h00);
		rc(22'h041010, 8'h00);
		er(22'h004000, 8'h50);
		rc(22'h005000, 8'hff);
	endtask
	task automatic t_broken();
		prog_u.wr(22'h015555, 8'haa);
		prog_u.wr(22'h012aaa, 8'h55);
		prog_u.wr(22'h015555, 8'ha0);
		prog_u.wr(22'h005020, 8'h00);
		rc(22'h005020, 8'h00);
		prog_u.wr(22'h00d555, 8'haa);
		prog_u.wr(22'h002aaa, 8'h55);
		prog_u.wr(22'h005555, 8'ha0);
		prog_u.wr(22'h005030, 8'h00);
		rc(22'h005030, 8'hff);
	endtask
	task automatic t_guard();
		prog_u.P.wp_n = 1'b0;
		pg(22'h005040, 8'h00);
		rc(22'h005040, 8'hff);
		prog_u.P.wp_n = 1'b1;
		er(22'h03c000, 8'h50);
		pg(22'h03c010, 8'h00);
		prog_u.P.boot_lock_pin_n = 1'b0;
		er(22'h03c000, 8'h30);
		rc(22'h03c010, 8'h00);
		prog_u.P.boot_lock_pin_n = 1'b1;
	endtask
	task automatic t_chip();
		prog_u.P.wp_n = 1'b0;
		prog_u.P.boot_lock_pin_n = 1'b0;
		prog_u.cmd(8'h80);
		prog_u.wr(22'h005555, 8'haa);
		prog_u.wr(22'h002aaa, 8'h55);
		prog_u.strobe(22'h005555, 8'h10);
		chk({7'h00, busy}, 8'h01);
		prog_u.P.rst_n = 1'b0;
		repeat (8) @(negedge clk);
		chk({7'h00, busy}, 8'h00);
		prog_u.P.rst_n = 1'b1;
		prog_u.P.wp_n = 1'b1;
		prog_u.P.boot_lock_pin_n = 1'b1;
		repeat (6) @(negedge clk);
		rc(22'h001010, 8'h00);
		rc(22'h03c010, 8'h00);
	endtask
	task automatic t_ident();
		prog_u.cmd(8'h90);
		rc(22'h000000, 8'h5a);
		rc(22'h000003, 8'h5a);
		rc(22'h03fff1, 8'h21);
		prog_u.wr(22'h001234, 8'hf0);
		rc(22'h001010, 8'h00);
		prog_u.cmd(8'h90);
		prog_u.cmd(8'hf0);
		rc(22'h001010, 8'h00);
	endtask
	task automatic close_out();
		err_count += prog_u.stall_count;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_float();
		t_sector();
		t_broken();
		t_guard();
		t_chip();
		t_ident();
		close_out();
	end
	initial begin
		repeat (99000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
